// >>> inc/ssb_defines.vh
// Constants for the stream scan buffer and timing block
`ifndef SSB_DEFINES_VH
`define SSB_DEFINES_VH

// ----------------------------------------
// Register offsets as printed
// ----------------------------------------
`define SSB_REG_BUF_SIZE     16'h0fac
`define SSB_REG_START_TIME   16'h0fba
`define SSB_REG_TICK         16'hf050

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define SSB_BUF_SIZE_RST     32'h00000000
`define SSB_BUF_SIZE_MAX     32'h00008000
`define SSB_TICK_RST         32'h00000000
`define SSB_CAPTURE_RST      32'h00000000

// ----------------------------------------
// Error codes
// ----------------------------------------
`define SSB_ERR_NONE         16'h0000
`define SSB_ERR_COLLISION    16'h0b7e
`define SSB_ERR_OVF_TIMEOUT  16'h0b7f

// ----------------------------------------
// Timing
// ----------------------------------------
`define SSB_CLK_MHZ          50
`define SSB_TICK_DIV         2
`define SSB_OVF_TIMEOUT_US   1000
`define SSB_OVF_TIMEOUT_CYC  (`SSB_OVF_TIMEOUT_US * `SSB_CLK_MHZ)

`endif

// >>> logic/ssb_mem.v
// Sample storage memory with registered read data
`timescale 1ns/1ns
module ssb_mem
#(
  parameter AW = 14,                  // Address width
  parameter DW = 16                   // Word width
)
(
  // Clock and enable
  input  wire          mclk_in,
  input  wire          ce_in,
  // Write side
  input  wire          wr_en_in,
  input  wire [AW-1:0] wr_addr_in,
  input  wire [DW-1:0] wr_data_in,
  // Read side
  input  wire          rd_en_in,
  input  wire [AW-1:0] rd_addr_in,
  output reg  [DW-1:0] rd_data_out
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg [DW-1:0] mem [0:(1<<AW)-1];     // No reset, contents are don't care

  // Write port and registered read port
  always @(posedge mclk_in)
  begin
    if (ce_in)
    begin
      if (wr_en_in)
        mem[wr_addr_in] <= wr_data_in;
      if (rd_en_in)
        rd_data_out <= mem[rd_addr_in];
    end
  end

endmodule // ssb_mem

// >>> logic/ssb_stream.v
// Stream scan pacing, collision check, sample FIFO and timestamp capture
//
// Functional notes
// - Scan start during busy scan halts, code 2942
// - Scans start at fixed period intervals
// - Samples stored in FIFO until host reads
// - Buffer size programmable, maximum 32768 bytes
// - Zero buffer size selects default capacity
// - Size change applies only to next stream
// - Overflow drops data until FIFO fully drained
// - Dropped scans counted and reported to host
// - Prolonged overflow ends stream with error
// - Scan list channels serviced back to back
// - Pulse pin marks scan and sample edges
// - Stream start captures tick counter value
// - First scan one period after capture
// - Tick counter 32 bits, half clock rate
// - Each sample is one 16-bit word
`timescale 1ns/1ns
`include "ssb_defines.vh"
module ssb_stream
#(
  parameter        AW                 = 14,            // log2 of sample capacity
  parameter        CW                 = 8,             // Channel index width
  parameter [31:0] DEFAULT_BYTES      = 32'h00001000,  // Capacity when size is zero
  parameter [31:0] OVF_TIMEOUT_CYCLES = `SSB_OVF_TIMEOUT_CYC
)
(
  // Clock, reset, enable
  input  wire          mclk_in,
  input  wire          reset_in,
  input  wire          ce_in,
  // Stream control
  input  wire          stream_start_in,
  input  wire          stream_stop_in,
  input  wire [31:0]   scan_period_in,
  input  wire [CW-1:0] num_chans_in,
  // Sampler handshake
  input  wire          sample_done_in,
  input  wire [15:0]   sample_data_in,
  output reg           sample_req_out,
  output reg  [CW-1:0] sample_chan_out,
  // Register port
  input  wire [15:0]   reg_addr_in,
  input  wire          reg_wr_in,
  input  wire          reg_rd_in,
  input  wire [31:0]   reg_wdata_in,
  output reg  [31:0]   reg_rdata_out,
  output reg           reg_ack_out,
  // Sample output to host link
  input  wire          out_ready_in,
  output reg           out_valid_out,
  output reg  [15:0]   out_data_out,
  // Status
  output reg           streaming_out,
  output reg           scan_collision_error_out,
  output reg           ovf_timeout_error_out,
  output reg  [15:0]   error_code_out,
  output reg  [31:0]   lost_scans_out,
  output reg           scan_phase_pulse_pin_out
);

  // ----------------------------------------
  // Local types and states
  // ----------------------------------------
  localparam [1:0] ST_IDLE = 2'b00;   // Waiting for scan start
  localparam [1:0] ST_REQ  = 2'b01;   // Issuing a sample request
  localparam [1:0] ST_WAIT = 2'b10;   // Waiting for sample done
  localparam [1:0] ST_END  = 2'b11;   // Closing the scan
  localparam [AW:0] CAP_MAX = {1'b1, {AW{1'b0}}}; // Memory depth bounds the capacity

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [31:0]   stream_buffer_size;        // Programmed size in bytes
  reg [31:0]   stream_start_time_capture; // Tick value at stream start
  reg [31:0]   free_running_tick_counter; // Half-rate core tick
  reg          tick_phase;                // Divides clock by two
  reg          tick_new;                  // Tick changed last cycle
  reg [31:0]   next_scan_time;            // Tick value of next scan
  reg [1:0]    state;                     // Scan sequencer state
  reg [AW:0]   cap_samples;               // Active capacity in samples
  reg [AW:0]   count;                     // Words held in memory
  reg [AW-1:0] wptr;                      // Write pointer
  reg [AW-1:0] rptr;                      // Read pointer
  reg          dropping;                  // Overflow discard mode
  reg          scan_dropped;              // Current scan lost data
  reg [31:0]   ovf_cycles;                // Time spent in overflow
  reg          rd_pend;                   // Memory read in flight
  reg          tail_valid;                // Second buffer slot used
  reg [15:0]   tail_data;                 // Second buffer slot word

  // ----------------------------------------
  // Combinational helpers
  // ----------------------------------------
  wire [15:0]  mem_rdata;                 // Memory read word
  wire         pop    = out_valid_out & out_ready_in;
  wire [1:0]   slots  = {1'b0, out_valid_out} + {1'b0, tail_valid} + {1'b0, rd_pend};
  // Read only when the word has a free slot on arrival
  // Reads go on after a stop so kept samples still drain
  wire         rd_issue = ~stream_start_in & (count != {(AW+1){1'b0}}) &
                          ((slots < 2'd2) | ((slots == 2'd2) & pop));
  // Scan tick: fires once when the tick counter reaches the target
  wire         scan_fire = streaming_out & tick_new & (free_running_tick_counter == next_scan_time);
  wire         last_chan = (sample_chan_out == num_chans_in - {{(CW-1){1'b0}}, 1'b1});
  wire         smp_in   = streaming_out & (state == ST_WAIT) & sample_done_in;
  wire         full     = (count == cap_samples);
  wire         wr_en    = smp_in & ~dropping & ~full;
  reg  [AW:0]  next_cap;                  // Capacity latched at start
  reg  [31:0]  size_sel;                  // Size after zero default

  // Capacity from the size register
  always @*
  begin
    size_sel = (stream_buffer_size == `SSB_BUF_SIZE_RST) ? DEFAULT_BYTES
                                                         : stream_buffer_size;
    if ((size_sel > `SSB_BUF_SIZE_MAX) || ((size_sel >> 1) > (32'h00000001 << AW)))
      next_cap = CAP_MAX;
    else
      next_cap = size_sel[AW+1:1];                              // Bytes to samples
  end

  // ----------------------------------------
  // Sample memory
  // ----------------------------------------
  ssb_mem #(.AW(AW), .DW(16)) u_mem
  (
    .mclk_in     (mclk_in),
    .ce_in       (ce_in),
    .wr_en_in    (wr_en),
    .wr_addr_in  (wptr),
    .wr_data_in  (sample_data_in),
    .rd_en_in    (rd_issue),
    .rd_addr_in  (rptr),
    .rd_data_out (mem_rdata)
  );

  // ----------------------------------------
  // Tick counter
  // ----------------------------------------
  // Counts every second clock and wraps silently
  always @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      free_running_tick_counter <= `SSB_TICK_RST;
      tick_phase                <= 1'b0;
      tick_new                  <= 1'b0;
    end
    else if (ce_in)
    begin
      tick_phase <= ~tick_phase;
      tick_new   <= tick_phase;
      if (tick_phase)
        free_running_tick_counter <= free_running_tick_counter + 32'h00000001;
    end
  end

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  // Reads answer one cycle later; unmapped reads give zero
  always @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      stream_buffer_size <= `SSB_BUF_SIZE_RST;
      reg_rdata_out      <= 32'h00000000;
      reg_ack_out        <= 1'b0;
    end
    else if (ce_in)
    begin
      reg_ack_out <= reg_rd_in | reg_wr_in;
      // Size only stored here; it is sampled at stream start
      if (reg_wr_in && reg_addr_in == `SSB_REG_BUF_SIZE)
        stream_buffer_size <= reg_wdata_in;
      if (reg_rd_in)
      begin
        case (reg_addr_in)
          `SSB_REG_BUF_SIZE:   reg_rdata_out <= stream_buffer_size;
          `SSB_REG_START_TIME: reg_rdata_out <= stream_start_time_capture;
          `SSB_REG_TICK:       reg_rdata_out <= free_running_tick_counter;
          default:             reg_rdata_out <= 32'h00000000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Stream control, scan sequencer, FIFO write
  // ----------------------------------------
  always @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      streaming_out             <= 1'b0;
      scan_collision_error_out  <= 1'b0;
      ovf_timeout_error_out     <= 1'b0;
      error_code_out            <= `SSB_ERR_NONE;
      stream_start_time_capture <= `SSB_CAPTURE_RST;
      next_scan_time            <= 32'h00000000;
      cap_samples               <= {(AW+1){1'b0}};
      state                     <= ST_IDLE;
      sample_req_out            <= 1'b0;
      sample_chan_out           <= {CW{1'b0}};
      scan_phase_pulse_pin_out  <= 1'b1;
      count                     <= {(AW+1){1'b0}};
      wptr                      <= {AW{1'b0}};
      rptr                      <= {AW{1'b0}};
      dropping                  <= 1'b0;
      scan_dropped              <= 1'b0;
      ovf_cycles                <= 32'h00000000;
      lost_scans_out            <= 32'h00000000;
    end
    else if (ce_in)
    begin
      sample_req_out <= 1'b0;
      if (stream_start_in)
      begin
        // New session: fresh FIFO, capacity and timing reference
        streaming_out             <= 1'b1;
        scan_collision_error_out  <= 1'b0;
        ovf_timeout_error_out     <= 1'b0;
        error_code_out            <= `SSB_ERR_NONE;
        stream_start_time_capture <= free_running_tick_counter;
        next_scan_time            <= free_running_tick_counter + scan_period_in;
        cap_samples               <= next_cap;
        state                     <= ST_IDLE;
        scan_phase_pulse_pin_out  <= 1'b1;
        count                     <= {(AW+1){1'b0}};
        wptr                      <= {AW{1'b0}};
        rptr                      <= {AW{1'b0}};
        dropping                  <= 1'b0;
        scan_dropped              <= 1'b0;
        ovf_cycles                <= 32'h00000000;
        lost_scans_out            <= 32'h00000000;
      end
      else if (stream_stop_in)
      begin
        streaming_out            <= 1'b0;
        state                    <= ST_IDLE;
        scan_phase_pulse_pin_out <= 1'b1;
      end
      else if (streaming_out)
      begin
        // Scan pacing at a fixed period
        if (scan_fire)
          next_scan_time <= next_scan_time + scan_period_in;
        // A tick while the previous scan runs ends the stream
        if (scan_fire && state != ST_IDLE)
        begin
          streaming_out            <= 1'b0;
          scan_collision_error_out <= 1'b1;
          error_code_out           <= `SSB_ERR_COLLISION;
          state                    <= ST_IDLE;
          scan_phase_pulse_pin_out <= 1'b1;
        end
        else
        begin
          case (state)
            ST_IDLE:
            begin
              if (scan_fire)
              begin
                scan_phase_pulse_pin_out <= 1'b0;              // scan start
                sample_chan_out          <= {CW{1'b0}};
                scan_dropped             <= 1'b0;
                state                    <= ST_REQ;
              end
            end
            ST_REQ:
            begin
              scan_phase_pulse_pin_out <= 1'b1;                // sample start
              sample_req_out           <= 1'b1;
              state                    <= ST_WAIT;
            end
            ST_WAIT:
            begin
              if (sample_done_in)
              begin
                scan_phase_pulse_pin_out <= 1'b0;              // sample end
                if (!wr_en)
                  scan_dropped <= 1'b1;
                if (last_chan)
                  state <= ST_END;
                else
                begin
                  sample_chan_out <= sample_chan_out + {{(CW-1){1'b0}}, 1'b1};
                  state           <= ST_REQ;
                end
              end
            end
            ST_END:
            begin
              scan_phase_pulse_pin_out <= 1'b1;                // scan end
              if (scan_dropped)
                lost_scans_out <= lost_scans_out + 32'h00000001;
              state <= ST_IDLE;
            end
            default:
              state <= ST_IDLE;
          endcase
        end
        // Overflow detection, discard mode and its timeout
        if (smp_in && !dropping && full)
          dropping <= 1'b1;
        else if (dropping && count == {(AW+1){1'b0}})
          dropping <= 1'b0;
        if (dropping)
        begin
          ovf_cycles <= ovf_cycles + 32'h00000001;
          if (ovf_cycles >= OVF_TIMEOUT_CYCLES - 32'h00000001)
          begin
            streaming_out            <= 1'b0;
            ovf_timeout_error_out    <= 1'b1;
            error_code_out           <= `SSB_ERR_OVF_TIMEOUT;
            state                    <= ST_IDLE;
            scan_phase_pulse_pin_out <= 1'b1;
          end
        end
        else
          ovf_cycles <= 32'h00000000;
      end
      // Pointer and occupancy bookkeeping, also after a stop
      if (!stream_start_in)
      begin
        if (wr_en)
          wptr <= wptr + {{(AW-1){1'b0}}, 1'b1};
        if (rd_issue)
          rptr <= rptr + {{(AW-1){1'b0}}, 1'b1};
        if (wr_en && !rd_issue)
          count <= count + {{AW{1'b0}}, 1'b1};
        else if (!wr_en && rd_issue)
          count <= count - {{AW{1'b0}}, 1'b1};
      end
    end
  end

  // ----------------------------------------
  // Two-entry output buffer
  // ----------------------------------------
  // Slots are reserved before the read, so a stall never loses a word
  always @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      rd_pend       <= 1'b0;
      out_valid_out <= 1'b0;
      out_data_out  <= 16'h0000;
      tail_valid    <= 1'b0;
      tail_data     <= 16'h0000;
    end
    else if (ce_in)
    begin
      rd_pend <= rd_issue;
      if (rd_pend && pop)
      begin
        // Word in and word out together
        if (tail_valid)
        begin
          out_data_out <= tail_data;
          tail_data    <= mem_rdata;
        end
        else
          out_data_out <= mem_rdata;
      end
      else if (rd_pend)
      begin
        if (!out_valid_out)
        begin
          out_data_out  <= mem_rdata;
          out_valid_out <= 1'b1;
        end
        else
        begin
          tail_data  <= mem_rdata;
          tail_valid <= 1'b1;
        end
      end
      else if (pop)
      begin
        if (tail_valid)
        begin
          out_data_out <= tail_data;
          tail_valid   <= 1'b0;
        end
        else
          out_valid_out <= 1'b0;
      end
    end
  end

endmodule // ssb_stream

// >>> sim/ssb_stream_properties.sv
// Port-level assertions for the stream scan buffer block
`timescale 1ns/1ns
module ssb_stream_properties
(
  // Clock, reset and inputs
  input wire        mclk_in,
  input wire        reset_in,
  input wire        ce_in,
  input wire        stream_start_in,
  input wire        sample_done_in,
  input wire        reg_rd_in,
  input wire        reg_wr_in,
  input wire        out_ready_in,
  // Outputs watched
  input wire        sample_req_out,
  input wire        reg_ack_out,
  input wire        out_valid_out,
  input wire [15:0] out_data_out,
  input wire        streaming_out,
  input wire        scan_collision_error_out,
  input wire        ovf_timeout_error_out,
  input wire [15:0] error_code_out,
  input wire [31:0] lost_scans_out,
  input wire        scan_phase_pulse_pin_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (reset_in);
  // Sample start: pin rises together with the request
  sequence s_sample_start;
    $rose(scan_phase_pulse_pin_out) && sample_req_out;
  endsequence
  // Sample end: pin low for one cycle, then high for next sample or scan end
  sequence s_sample_end;
    !scan_phase_pulse_pin_out ##1 scan_phase_pulse_pin_out;
  endsequence
  property p_req_edge;
    sample_req_out |-> s_sample_start;
  endproperty
  a_req_edge: assert property (p_req_edge) else $error("request without pin rise");
  property p_done_edge;
    sample_done_in && streaming_out && scan_phase_pulse_pin_out && !sample_req_out |=> !streaming_out or s_sample_end;
  endproperty
  a_done_edge: assert property (p_done_edge) else $error("pin wrong after sample end");
  property p_req_pulse;
    sample_req_out |=> !sample_req_out;
  endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("request longer than one cycle");
  property p_collision;
    $rose(scan_collision_error_out) |-> error_code_out == 16'h0b7e && !streaming_out;
  endproperty
  a_collision: assert property (p_collision) else $error("collision code or halt wrong");
  property p_ovf_timeout;
    $rose(ovf_timeout_error_out) |-> error_code_out == 16'h0b7f && !streaming_out;
  endproperty
  a_ovf_timeout: assert property (p_ovf_timeout) else $error("timeout code or halt wrong");
  property p_reg_ack;
    ce_in && (reg_rd_in || reg_wr_in) |=> reg_ack_out;
  endproperty
  a_reg_ack: assert property (p_reg_ack) else $error("register access not acknowledged");
  property p_ack_cause;
    reg_ack_out |-> $past(ce_in && (reg_rd_in || reg_wr_in));
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("acknowledge without access");
  property p_out_hold;
    out_valid_out && !out_ready_in |=> out_valid_out && $stable(out_data_out);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("stalled word lost or changed");
  property p_lost_step;
    !$past(stream_start_in) && lost_scans_out != $past(lost_scans_out) |-> lost_scans_out == $past(lost_scans_out) + 32'h1;
  endproperty
  a_lost_step: assert property (p_lost_step) else $error("lost count stepped wrongly");
  property p_start_run;
    stream_start_in |=> streaming_out && !scan_collision_error_out && !ovf_timeout_error_out && lost_scans_out == 32'h0;
  endproperty
  a_start_run: assert property (p_start_run) else $error("start did not run clean");
endmodule // ssb_stream_properties

bind ssb_stream ssb_stream_properties u_props (.mclk_in, .reset_in, .ce_in, .stream_start_in, .sample_done_in,
  .reg_rd_in, .reg_wr_in, .out_ready_in, .sample_req_out, .reg_ack_out, .out_valid_out, .out_data_out,
  .streaming_out, .scan_collision_error_out, .ovf_timeout_error_out, .error_code_out, .lost_scans_out,
  .scan_phase_pulse_pin_out);

// >>> sim/ssb_host_model.sv
// Host-side drain model for the stream output link
`timescale 1ns/1ns
module ssb_host_model
(
  // Clock and pacing control
  input  wire        mclk_in,
  input  wire        stall_in,
  input  wire        slow_in,
  // Stream link
  input  wire        valid_in,
  input  wire [15:0] data_in,
  output reg         ready_out,
  // Words taken by the host
  output reg         got_out,
  output reg  [15:0] word_out
);
  reg [1:0] pace; // Slow mode takes one word in four cycles
  initial
  begin
    pace = 2'h0;
    ready_out = 1'b0;
    got_out = 1'b0;
    word_out = 16'h0000;
  end
  // Ready changes only after the falling edge, like a real link
  always @(negedge mclk_in)
  begin
    pace <= pace + 2'h1;
    ready_out <= !stall_in && (!slow_in || pace == 2'h0);
  end
  // A word is taken on an edge with valid and ready both high
  always @(posedge mclk_in)
  begin
    got_out <= valid_in && ready_out;
    word_out <= data_in;
  end
endmodule // ssb_host_model

// >>> sim/ssb_stream_tb.sv
// Self-checking bench for the stream scan buffer block
`timescale 1ns/1ns
`include "ssb_defines.vh"
module ssb_stream_tb;
  localparam [31:0] DEF_BYTES = 32'h00000010; // Default capacity, eight words
  reg          mclk_in, reset_in, ce_in, stream_start_in, stream_stop_in, sample_done_in;
  reg          reg_wr_in, reg_rd_in, stall, slow, drop_scan;
  reg  [31:0]  scan_period_in, reg_wdata_in, rd, tick0;
  reg  [7:0]   num_chans_in;
  reg  [15:0]  sample_data_in, reg_addr_in;
  wire         sample_req_out, reg_ack_out, out_ready_in, out_valid_out, streaming_out, got;
  wire         scan_collision_error_out, ovf_timeout_error_out, scan_phase_pulse_pin_out;
  wire [7:0]   sample_chan_out;
  wire [15:0]  out_data_out, error_code_out, word;
  wire [31:0]  reg_rdata_out, lost_scans_out;
  integer      failures, tests_run, cyc, wait_n, exp_chan, sent, keep_lim, exp_lost, last_fire, t_start, k;
  logic [15:0] expq[$]; // Words the host should see, in order
  ssb_stream #(.AW(4), .CW(8), .DEFAULT_BYTES(DEF_BYTES), .OVF_TIMEOUT_CYCLES(32'd40)) DUT (.mclk_in, .reset_in,
    .ce_in, .stream_start_in, .stream_stop_in, .scan_period_in, .num_chans_in, .sample_done_in, .sample_data_in,
    .sample_req_out, .sample_chan_out, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out,
    .reg_ack_out, .out_ready_in, .out_valid_out, .out_data_out, .streaming_out, .scan_collision_error_out,
    .ovf_timeout_error_out, .error_code_out, .lost_scans_out, .scan_phase_pulse_pin_out);
  ssb_host_model u_host (.mclk_in, .stall_in(stall), .slow_in(slow), .valid_in(out_valid_out),
    .data_in(out_data_out), .ready_out(out_ready_in), .got_out(got), .word_out(word));
  initial
  begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end
  // Cycle count doubles as the hang limit
  always @(posedge mclk_in)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      failures = failures + 1;
      report_and_stop;
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp)
      begin
        failures = failures + 1;
        $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // One register access; read data lands one cycle after the strobe
  task reg_acc(input logic wr, input logic [15:0] addr, input logic [31:0] wd);
    begin
      @(negedge mclk_in);
      reg_wr_in = wr;
      reg_rd_in = !wr;
      reg_addr_in = addr;
      reg_wdata_in = wd;
      @(posedge mclk_in);
      #1 rd = reg_rdata_out;
      check(reg_ack_out, 32'h1);
      @(negedge mclk_in);
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
    end
  endtask
  // Start a stream and read the tick counter on the same edge
  task start_stream(input logic [31:0] p, input logic [7:0] n);
    begin
      @(negedge mclk_in);
      scan_period_in = p;
      num_chans_in = n;
      exp_chan = 0;
      last_fire = -1;
      sent = 0;
      exp_lost = 0;
      stream_start_in = 1'b1;
      reg_rd_in = 1'b1;
      reg_addr_in = `SSB_REG_TICK;
      @(negedge mclk_in);
      t_start = cyc;
      stream_start_in = 1'b0;
      reg_rd_in = 1'b0;
      @(posedge mclk_in);
      #1 tick0 = reg_rdata_out;
      reg_acc(1'b0, `SSB_REG_START_TIME, 32'h0);
      check(rd, tick0);
    end
  endtask
  // Sampler: answers each request after one or two cycles with a random word
  always @(negedge mclk_in)
  begin
    sample_done_in = 1'b0;
    if (sample_req_out === 1'b1)
    begin
      check(sample_chan_out, exp_chan);
      if (exp_chan == 0 && last_fire >= 0)
        check(cyc - last_fire, 2 * scan_period_in);
      else if (exp_chan == 0)
        check(cyc - t_start >= 2 * scan_period_in && cyc - t_start <= 2 * scan_period_in + 3, 1);
      if (exp_chan == 0)
        last_fire = cyc;
      if (exp_chan == 0)
        drop_scan = 1'b0;
      wait_n = 1 + $urandom % 2;
    end
    else if (wait_n > 0)
    begin
      wait_n = wait_n - 1;
      if (wait_n == 0)
      begin
        sample_done_in = 1'b1;
        sample_data_in = $urandom;
        if (sent < keep_lim && streaming_out === 1'b1)
          expq.push_back(sample_data_in);
        else
          drop_scan = 1'b1;
        sent = sent + 1;
        if (exp_chan == num_chans_in - 1 && drop_scan && streaming_out === 1'b1)
          exp_lost = exp_lost + 1;
        exp_chan = (exp_chan + 1) % num_chans_in;
      end
    end
  end
  // Every word the host takes must be the oldest kept sample
  always @(negedge mclk_in)
    if (got === 1'b1)
      check(word, expq.size() > 0 ? {16'h0, expq.pop_front()} : 32'h10000);
  initial
  begin
    {reset_in, ce_in, stall, slow, keep_lim, cyc, failures, tests_run, wait_n} = {4'b1101, 160'h0};
    {stream_start_in, stream_stop_in, sample_done_in, reg_wr_in, reg_rd_in, drop_scan} = 6'h0;
    {scan_period_in, reg_wdata_in, num_chans_in, sample_data_in, reg_addr_in} = {32'h1, 32'h0, 8'h1, 32'h0};
    {exp_chan, sent, exp_lost, last_fire, t_start} = 160'h0;
    rd = $urandom(32'h009a);
    repeat (6) @(negedge mclk_in);
    reset_in = 1'b0;
    reg_acc(1'b0, `SSB_REG_BUF_SIZE, 32'h0);
    check(rd, `SSB_BUF_SIZE_RST);
    reg_acc(1'b0, 16'h0123, 32'h0);
    check(rd, 32'h0);
    reg_acc(1'b1, `SSB_REG_START_TIME, 32'h5a5a);
    reg_acc(1'b0, `SSB_REG_START_TIME, 32'h0);
    check(rd, `SSB_CAPTURE_RST);
    reg_acc(1'b1, `SSB_REG_BUF_SIZE, `SSB_BUF_SIZE_MAX);
    reg_acc(1'b0, `SSB_REG_BUF_SIZE, 32'h0);
    check(rd, `SSB_BUF_SIZE_MAX);
    reg_acc(1'b0, `SSB_REG_TICK, 32'h0);
    tick0 = rd;
    reg_acc(1'b0, `SSB_REG_TICK, 32'h0);
    check(rd - tick0, 32'h1);
    reg_acc(1'b1, `SSB_REG_BUF_SIZE, 32'h0);
    $display("test registers done");
    // Plain stream, host slow but keeping up
    keep_lim = 1000;
    start_stream(32'd10, 8'd3);
    repeat (90) @(negedge mclk_in);
    while (wait_n != 0 || sample_req_out === 1'b1) @(negedge mclk_in);
    stream_stop_in = 1'b1;
    @(negedge mclk_in);
    stream_stop_in = 1'b0;
    repeat (40) @(negedge mclk_in);
    check(expq.size(), 32'h0);
    check(lost_scans_out, 32'h0);
    $display("test stream done");
    // Overflow: host stalls, default capacity plus two buffer slots survive
    stall = 1'b1;
    keep_lim = DEF_BYTES / 2 + 2;
    start_stream(32'd10, 8'd2);
    reg_acc(1'b1, `SSB_REG_BUF_SIZE, 32'h20);
    for (k = 0; k < 2000 && ovf_timeout_error_out !== 1'b1; k = k + 1) @(negedge mclk_in);
    check(ovf_timeout_error_out, 32'h1);
    check(error_code_out, `SSB_ERR_OVF_TIMEOUT);
    check(lost_scans_out, exp_lost);
    {stall, slow} = 2'b00;
    repeat (60) @(negedge mclk_in);
    check(expq.size(), 32'h0);
    $display("test overflow done");
    // Collision: scan period far shorter than a four-channel scan
    keep_lim = 1000;
    start_stream(32'd2, 8'd4);
    check(ovf_timeout_error_out, 32'h0);
    for (k = 0; k < 500 && scan_collision_error_out !== 1'b1; k = k + 1) @(negedge mclk_in);
    check(scan_collision_error_out, 32'h1);
    check(error_code_out, `SSB_ERR_COLLISION);
    check(streaming_out, 32'h0);
    $display("test collision done");
    report_and_stop;
  end
endmodule // ssb_stream_tb
